// ### pkg/ctpwm_pkg.sv
// Purpose: Shared constants and carriers of the compact timer PWM block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Reset values and field positions live here only
package ctpwm_pkg;

    localparam int unsigned CNT_W = 10;
    localparam int unsigned COMPARE_P_PERIOD_W = 3;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned IRQ_W = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_CMPA = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_ENABLE = 8'h14;
    localparam logic [7:0] OFS_CLEAR = 8'h18;
    localparam logic [7:0] OFS_PIN = 8'h1C;

    // Control word 0 layout
    localparam int unsigned EN_POS = 3;
    localparam int unsigned COMPARE_P_PERIOD_LSB = 0;
    // Interrupt bit positions
    localparam int unsigned IRQ_A_POS = 0;
    localparam int unsigned IRQ_P_POS = 1;

    // Reset values
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [9:0] CMPA_RST = 10'h000;
    localparam logic [9:0] COUNT_RST = 10'h000;
    localparam logic [2:0] COMPARE_P_PERIOD_RST = 3'h0;
    localparam logic [1:0] IRQ_RST = 2'h0;
    localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

    // Period arithmetic: 3-bit code steps in 128 clocks, zero means 1024
    localparam int unsigned STEP_LSB = 7;
    localparam logic [10:0] PERIOD_FULL = 11'h400;
    localparam logic [10:0] COUNT_ONE = 11'h001;

    ////////////////////////////////////////////////////////////////////////////////
    // Modes and pin functions
    typedef enum logic [1:0] {
        MODE_COMPARE = 2'h0,
        MODE_UNDEF = 2'h1,
        MODE_TIMER = 2'h3,
        MODE_PWM = 2'h2
    } ctpwm_mode_e;

    // PWM mode pin functions
    localparam logic [1:0] PF_INACTIVE = 2'h0;
    localparam logic [1:0] PF_ACTIVE = 2'h1;
    localparam logic [1:0] PF_WAVE = 2'h2;
    // Compare mode pin functions
    localparam logic [1:0] CM_LOW = 2'h1;
    localparam logic [1:0] CM_HIGH = 2'h2;
    localparam logic [1:0] CM_TOGGLE = 2'h3;

    typedef struct packed {
        ctpwm_mode_e mode;
        logic [1:0] pin_function;
        logic output_control;
        logic output_polarity;
        logic duty_period_swap;
        logic counter_clear_select;
    } ctpwm_ctrl1_s;

    typedef struct packed {
        ctpwm_ctrl1_s ctrl1;
        logic timer_enable;
        logic [2:0] compare_p_period;
        logic [9:0] compare_a_value;
    } ctpwm_cfg_s;

    typedef struct packed {
        logic [9:0] new_count;
        logic clear;
        logic a_flag;
        logic p_flag;
        logic active;
    } ctpwm_hit_s;

    typedef struct packed {
        ctpwm_cfg_s cfg;
        logic [9:0] count;
        logic pin_level;
        logic pin_out;
        logic pin_oe_n;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ctpwm_main_s;

    typedef struct packed {
        logic [1:0] status;
        logic [1:0] enable;
        logic irq;
    } ctpwm_irq_s;

endpackage

// ### hw/ctpwm_match.sv
// Purpose: Comparators, counter step and PWM duty decision
// Assumes: Purely combinational, evaluated every cycle
// Notes: Active level is judged on the count as it stands now
`timescale 1ns/1ps
module ctpwm_match (
    // Configuration and count
    input wire ctpwm_pkg::ctpwm_cfg_s i_cfg,
    input wire logic [9:0] i_count,
    // Results
    output ctpwm_pkg::ctpwm_hit_s o_hit
);
    logic [10:0] inc;
    logic [10:0] period;
    logic [10:0] duty;
    logic [10:0] compare_p_period_span;
    logic a_eq;
    logic p_eq;
    logic pwm;

    always_comb begin
        inc = {1'b0, i_count} + ctpwm_pkg::COUNT_ONE;
        pwm = (i_cfg.ctrl1.mode == ctpwm_pkg::MODE_PWM);
        a_eq = (inc[9:0] == i_cfg.compare_a_value) &&
            (i_cfg.compare_a_value != ctpwm_pkg::CMPA_RST);
        // Code zero is the natural overflow
        if (i_cfg.compare_p_period == ctpwm_pkg::COMPARE_P_PERIOD_RST) begin
            p_eq = inc[10];
            compare_p_period_span = ctpwm_pkg::PERIOD_FULL;
        end else begin
            p_eq = (inc[9:7] == i_cfg.compare_p_period) && (inc[6:0] == 7'h00);
            compare_p_period_span = {1'b0, i_cfg.compare_p_period, 7'h00};
        end
        o_hit.a_flag = a_eq;
        if (pwm) begin
            o_hit.p_flag = p_eq;
            if (i_cfg.ctrl1.duty_period_swap) begin
                o_hit.clear = a_eq || inc[10];
                period = (i_cfg.compare_a_value == ctpwm_pkg::CMPA_RST) ?
                    ctpwm_pkg::PERIOD_FULL : {1'b0, i_cfg.compare_a_value};
                duty = compare_p_period_span;
            end else begin
                o_hit.clear = p_eq;
                period = compare_p_period_span;
                duty = {1'b0, i_cfg.compare_a_value};
            end
        end else begin
            o_hit.p_flag = p_eq && !i_cfg.ctrl1.counter_clear_select;
            o_hit.clear = i_cfg.ctrl1.counter_clear_select ? a_eq : p_eq;
            period = ctpwm_pkg::PERIOD_FULL;
            duty = {1'b0, i_cfg.compare_a_value};
        end
        o_hit.new_count = o_hit.clear ? ctpwm_pkg::COUNT_RST : inc[9:0];
        o_hit.active = (duty >= period) || ({1'b0, i_count} < duty);
    end
endmodule

// ### hw/ctpwm_irq.sv
// Purpose: Sticky interrupt status, enable and clear
// Assumes: Set and clear pulses come from the same clock
// Notes: A set in the clearing cycle wins
`timescale 1ns/1ps
module ctpwm_irq (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_clock_enable,
    // Events and software access
    input wire logic [1:0] i_set,
    input wire logic i_enable_we,
    input wire logic [1:0] i_enable_data,
    input wire logic [1:0] i_clear,
    // State
    output logic [1:0] o_status,
    output logic [1:0] o_enable,
    output logic o_irq
);
    ctpwm_pkg::ctpwm_irq_s st;
    ctpwm_pkg::ctpwm_irq_s next_st;

    always_comb begin
        next_st = st;
        next_st.status = (st.status & ~i_clear) | i_set;
        if (i_enable_we) begin
            next_st.enable = i_enable_data;
        end
        next_st.irq = |(next_st.status & next_st.enable);
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            st <= '{status: ctpwm_pkg::IRQ_RST, enable: ctpwm_pkg::IRQ_RST, irq: 1'b0};
        end else if (i_clock_enable) begin
            st <= next_st;
        end
    end

    assign o_status = st.status;
    assign o_enable = st.enable;
    assign o_irq = st.irq;
endmodule

// ### hw/ctpwm_top.sv
// Purpose: Compact 10-bit timer with compare, timer/counter and PWM modes
// Assumes: i_count_tick is a one-cycle timer clock enable from this domain
// Notes: Registers over APB, one wait state on every access
// Notes on behaviour
// - A rising timer enable returns the pin to the level of output control.
// - In compare mode only a comparator-A match moves the pin.
// - Outside PWM mode, with counter clear select set, the comparator-P flag is never raised.
// - Mode code 11 counts and flags like compare mode but does not drive the pin.
// - In timer/counter mode the pin is released for other use.
// - Mode code 10 produces a fixed-frequency PWM wave set by the registers.
// - In PWM mode the clear select is ignored and the period register clears the counter.
// - The swap bit chooses which register sets period and which sets duty.
// - A 3-bit period code gives 128 to 896 clocks, code zero gives 1024.
// - A duty at or above the period holds the output active all period.
// - With swap set the 10-bit value is period and the 3-bit code is duty, zero excluded.
// - In PWM mode each comparator raises its own flag on a match.
// - Output control sets the active level, polarity inverts, pin function may force it.
// - With forced pin codes the PWM counting keeps running.
// - Pin codes 00 inactive, 01 active, 10 wave, 11 undefined.
// - Outside PWM a set clear select clears on A match, else on P match or overflow.
`timescale 1ns/1ps
module ctpwm_top (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_clock_enable,
    // Timer clock
    input wire logic i_count_tick,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // Timer pin
    output logic o_pin_out,
    output logic o_pin_oe_n,
    // Interrupt
    output logic o_irq
);
    ctpwm_pkg::ctpwm_main_s st;
    ctpwm_pkg::ctpwm_main_s next_st;
    ctpwm_pkg::ctpwm_hit_s hit;
    logic access;
    logic commit;
    logic wr;
    logic restart;
    logic [31:0] rdata;
    logic rd_err;
    logic [1:0] ev;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic [1:0] irq_clear;
    logic enable_we;
    logic oc;
    logic pwm;

    ////////////////////////////////////////////////////////////////////////////////
    // Comparators and interrupts

    ctpwm_match u_match (
        .i_cfg(st.cfg),
        .i_count(st.count),
        .o_hit(hit)
    );

    ctpwm_irq u_irq (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_clock_enable(i_clock_enable),
        .i_set(ev),
        .i_enable_we(enable_we),
        .i_enable_data(i_pwdata[1:0]),
        .i_clear(irq_clear),
        .o_status(irq_status),
        .o_enable(irq_enable),
        .o_irq(o_irq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    assign access = i_psel && i_penable;
    assign commit = i_clock_enable && access && st.pready;
    assign wr = commit && i_pwrite && !st.pslverr;
    assign enable_we = wr && (i_paddr == ctpwm_pkg::OFS_ENABLE);
    assign irq_clear = (wr && (i_paddr == ctpwm_pkg::OFS_CLEAR)) ? i_pwdata[1:0] : 2'h0;
    assign oc = st.cfg.ctrl1.output_control;
    assign pwm = (st.cfg.ctrl1.mode == ctpwm_pkg::MODE_PWM);

    always_comb begin
        rdata = ctpwm_pkg::PRDATA_RST;
        rd_err = 1'b0;
        if (i_paddr == ctpwm_pkg::OFS_CTRL0) begin
            rdata[ctpwm_pkg::EN_POS] = st.cfg.timer_enable;
            rdata[ctpwm_pkg::COMPARE_P_PERIOD_LSB +: 3] = st.cfg.compare_p_period;
        end else if (i_paddr == ctpwm_pkg::OFS_CTRL1) begin
            rdata[7:0] = st.cfg.ctrl1;
        end else if (i_paddr == ctpwm_pkg::OFS_COUNT) begin
            rdata[9:0] = st.count;
        end else if (i_paddr == ctpwm_pkg::OFS_CMPA) begin
            rdata[9:0] = st.cfg.compare_a_value;
        end else if (i_paddr == ctpwm_pkg::OFS_STATUS) begin
            rdata[1:0] = irq_status;
        end else if (i_paddr == ctpwm_pkg::OFS_ENABLE) begin
            rdata[1:0] = irq_enable;
        end else if (i_paddr == ctpwm_pkg::OFS_CLEAR) begin
            rdata[1:0] = 2'h0;
        end else if (i_paddr == ctpwm_pkg::OFS_PIN) begin
            rdata[1:0] = {st.pin_oe_n, st.pin_out};
        end else begin
            rd_err = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_st = st;
        restart = 1'b0;
        ev = 2'h0;
        // One wait state, answer latched at first access cycle
        next_st.pready = access && !st.pready;
        if (access && !st.pready) begin
            next_st.prdata = i_pwrite ? ctpwm_pkg::PRDATA_RST : rdata;
            next_st.pslverr = rd_err;
        end
        if (wr && (i_paddr == ctpwm_pkg::OFS_CTRL0)) begin
            next_st.cfg.timer_enable = i_pwdata[ctpwm_pkg::EN_POS];
            next_st.cfg.compare_p_period = i_pwdata[ctpwm_pkg::COMPARE_P_PERIOD_LSB +: 3];
            restart = i_pwdata[ctpwm_pkg::EN_POS] && !st.cfg.timer_enable;
        end else if (wr && (i_paddr == ctpwm_pkg::OFS_CTRL1)) begin
            next_st.cfg.ctrl1 = ctpwm_pkg::ctpwm_ctrl1_s'(i_pwdata[7:0]);
        end else if (wr && (i_paddr == ctpwm_pkg::OFS_CMPA)) begin
            next_st.cfg.compare_a_value = i_pwdata[9:0];
        end
        if (restart) begin
            next_st.count = ctpwm_pkg::COUNT_RST;
            next_st.pin_level = oc;
        end else if (st.cfg.timer_enable) begin
            if (i_count_tick) begin
                next_st.count = hit.new_count;
                ev[ctpwm_pkg::IRQ_A_POS] = hit.a_flag;
                ev[ctpwm_pkg::IRQ_P_POS] = hit.p_flag;
            end
            if (pwm) begin
                case (st.cfg.ctrl1.pin_function)
                    ctpwm_pkg::PF_INACTIVE: begin
                        next_st.pin_level = !oc;
                    end
                    ctpwm_pkg::PF_ACTIVE: begin
                        next_st.pin_level = oc;
                    end
                    ctpwm_pkg::PF_WAVE: begin
                        next_st.pin_level = hit.active ? oc : !oc;
                    end
                    default: begin
                        next_st.pin_level = !oc;
                    end
                endcase
            end else if (i_count_tick && hit.a_flag) begin
                case (st.cfg.ctrl1.pin_function)
                    ctpwm_pkg::CM_LOW: begin
                        next_st.pin_level = 1'b0;
                    end
                    ctpwm_pkg::CM_HIGH: begin
                        next_st.pin_level = 1'b1;
                    end
                    ctpwm_pkg::CM_TOGGLE: begin
                        next_st.pin_level = !st.pin_level;
                    end
                    default: begin
                        next_st.pin_level = st.pin_level;
                    end
                endcase
            end
        end
        // Released in timer/counter and undefined modes
        next_st.pin_oe_n = (st.cfg.ctrl1.mode == ctpwm_pkg::MODE_TIMER) ||
            (st.cfg.ctrl1.mode == ctpwm_pkg::MODE_UNDEF);
        next_st.pin_out = next_st.pin_oe_n ? 1'b0 :
            (next_st.pin_level ^ st.cfg.ctrl1.output_polarity);
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            st <= '{
                cfg: '{
                    ctrl1: ctpwm_pkg::ctpwm_ctrl1_s'(ctpwm_pkg::CTRL1_RST),
                    timer_enable: 1'b0,
                    compare_p_period: ctpwm_pkg::COMPARE_P_PERIOD_RST,
                    compare_a_value: ctpwm_pkg::CMPA_RST
                },
                count: ctpwm_pkg::COUNT_RST,
                pin_level: 1'b0,
                pin_out: 1'b0,
                pin_oe_n: 1'b0,
                pready: 1'b0,
                pslverr: 1'b0,
                prdata: ctpwm_pkg::PRDATA_RST
            };
        end else if (i_clock_enable) begin
            st <= next_st;
        end
    end

    assign o_pready = st.pready;
    assign o_prdata = st.prdata;
    assign o_pslverr = st.pslverr;
    assign o_pin_out = st.pin_out;
    assign o_pin_oe_n = st.pin_oe_n;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    logic run;
    logic [10:0] compare_p_period_span;
    assign run = i_clock_enable && st.cfg.timer_enable && !restart;
    assign compare_p_period_span = (st.cfg.compare_p_period == ctpwm_pkg::COMPARE_P_PERIOD_RST) ?
        ctpwm_pkg::PERIOD_FULL : {1'b0, st.cfg.compare_p_period, 7'h00};

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_reset);

    property p_restart;
        restart |=> (st.pin_level == $past(oc)) && (st.count == 10'h000);
    endproperty
    a_restart: assert property (p_restart) else $error("Enable rise did not restart");

    property p_p_quiet;
        (run && !pwm && !(i_count_tick && hit.a_flag)) |=> $stable(st.pin_level);
    endproperty
    a_p_quiet: assert property (p_p_quiet) else $error("Pin moved without an A match");

    property p_no_pflag;
        (run && !pwm && st.cfg.ctrl1.counter_clear_select) |-> !ev[1];
    endproperty
    a_no_pflag: assert property (p_no_pflag) else $error("P flag raised with clear on A");

    property p_timer_release;
        (i_clock_enable && st.cfg.ctrl1.mode == ctpwm_pkg::MODE_TIMER)
            |=> o_pin_oe_n && !o_pin_out;
    endproperty
    a_timer_release: assert property (p_timer_release) else $error("Pin driven in timer mode");

    property p_pwm_clear;
        (run && pwm && i_count_tick && !st.cfg.ctrl1.duty_period_swap && hit.p_flag)
            |=> st.count == 10'h000;
    endproperty
    a_pwm_clear: assert property (p_pwm_clear) else $error("Period match did not clear");

    property p_period_code;
        (run && pwm && !st.cfg.ctrl1.duty_period_swap &&
            st.count == {st.cfg.compare_p_period, 7'h00} - 10'h001) |-> hit.p_flag;
    endproperty
    a_period_code: assert property (p_period_code) else $error("Period code length wrong");

    property p_full_duty;
        (run && pwm && !st.cfg.ctrl1.duty_period_swap &&
            st.cfg.ctrl1.pin_function == ctpwm_pkg::PF_WAVE &&
            {1'b0, st.cfg.compare_a_value} >= compare_p_period_span) |=> st.pin_level == $past(oc);
    endproperty
    a_full_duty: assert property (p_full_duty) else $error("Full duty not held active");

    property p_flag_a;
        (run && pwm && i_count_tick && hit.a_flag) |=> irq_status[0];
    endproperty
    a_flag_a: assert property (p_flag_a) else $error("A match flag missing in PWM");

    property p_force_active;
        (run && pwm && st.cfg.ctrl1.pin_function == ctpwm_pkg::PF_ACTIVE)
            |=> o_pin_out == ($past(oc) ^ $past(st.cfg.ctrl1.output_polarity));
    endproperty
    a_force_active: assert property (p_force_active) else $error("Forced level wrong");

    property p_forced_runs;
        (run && pwm && i_count_tick && !st.cfg.ctrl1.pin_function[1])
            |=> (st.count == $past(st.count) + 10'h001) || (st.count == 10'h000);
    endproperty
    a_forced_runs: assert property (p_forced_runs) else $error("Counter stopped when forced");

    property p_clear_a;
        (run && !pwm && i_count_tick && st.cfg.ctrl1.counter_clear_select && hit.a_flag)
            |=> st.count == 10'h000;
    endproperty
    a_clear_a: assert property (p_clear_a) else $error("A match did not clear");

    c_pwm_wave: cover property (run && pwm && st.cfg.ctrl1.pin_function == ctpwm_pkg::PF_WAVE
        && hit.p_flag);
    c_irq: cover property (o_irq);
    c_toggle: cover property (run && !pwm && hit.a_flag && i_count_tick);
endmodule

// ### bench/ctpwm_load.sv
// Purpose: External load on the timer pin, resolves the wire level
// Assumes: Pin enable is low while the block drives the pin
// Notes: A released pin shows the inverse of the last driven level
`timescale 1ns/1ps
module ctpwm_load (
    // Clock
    input wire logic i_clock,
    // Pin from the block
    input wire logic i_pin_out,
    input wire logic i_pin_oe_n,
    // Resolved wire
    output logic o_level
);
    logic last = 1'b0;
    always_ff @(posedge i_clock) begin
        if (!i_pin_oe_n) begin
            last <= i_pin_out;
        end
    end
    // No keeper: a stale level must not pass for a driven one
    assign o_level = i_pin_oe_n ? ~last : i_pin_out;
endmodule

// ### bench/ctpwm_top_test.sv
// Purpose: Self-checking bench of the compact timer PWM block
// Assumes: One timer tick per clock unless a scenario says otherwise
// Notes: Registers reached over APB only
`timescale 1ns/1ps
module ctpwm_top_test;
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic tick = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic pready, perr, pin, oe_n, irq, level, serr;
    logic [31:0] prdata, q;
    int n_mismatch = 0;
    int n_tests = 0;
    int hi;
    always #20 i_clock = ~i_clock;
    ctpwm_top dut (.i_clock(i_clock), .i_reset(i_reset), .i_clock_enable(1'b1),
        .i_count_tick(tick), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
        .o_pslverr(perr), .o_pin_out(pin), .o_pin_oe_n(oe_n), .o_irq(irq));
    ctpwm_load load (.i_clock(i_clock), .i_pin_out(pin), .i_pin_oe_n(oe_n), .o_level(level));
    ////////////////////////////////////////////////////////////////////////////////
    task test_done;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        pen <= 1'b1;
        // Waits for the answer, only the watchdog ends a hang
        do begin
            @(posedge i_clock);
        end while (pready !== 1'b1);
        q = prdata;
        serr = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task run(input int n);
        hi = 0;
        repeat (n) begin
            @(posedge i_clock);
            if (level === 1'b1) begin
                hi++;
            end
        end
    endtask
    function automatic logic [7:0] ctl1(input ctpwm_pkg::ctpwm_mode_e m, input logic [1:0] pf,
        input logic oc, input logic pol, input logic sw, input logic ccs);
        return {m, pf, oc, pol, sw, ccs};
    endfunction
    // Stop, clear flags, configure, then restart the timer
    task setup(input logic [7:0] c1, input logic [2:0] pp, input logic [9:0] a);
        apb(1'b1, ctpwm_pkg::OFS_CTRL0, 32'h0000_0000);
        apb(1'b1, ctpwm_pkg::OFS_CLEAR, 32'h0000_0003);
        apb(1'b1, ctpwm_pkg::OFS_CTRL1, {24'h00_0000, c1});
        apb(1'b1, ctpwm_pkg::OFS_CMPA, {22'h00_0000, a});
        apb(1'b1, ctpwm_pkg::OFS_CTRL0, {28'h000_0000, 1'b1, pp});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        apb(1'b0, ctpwm_pkg::OFS_CTRL1, 32'h0000_0000);
        chk("ctrl1", q, {24'h00_0000, ctpwm_pkg::CTRL1_RST});
        apb(1'b0, ctpwm_pkg::OFS_STATUS, 32'h0000_0000);
        chk("status", q, 32'h0000_0000);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("unmapped error", {31'h0000_0000, serr}, 32'h0000_0001);
        chk("unmapped data", q, 32'h0000_0000);
    endtask
    task t_count;
        setup(ctl1(ctpwm_pkg::MODE_COMPARE, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0), 3'h1, 10'h000);
        apb(1'b0, ctpwm_pkg::OFS_COUNT, 32'h0000_0000);
        chk("count restart", q, 32'h0000_0000);
        @(posedge i_clock);
        tick <= 1'b1;
        repeat (5) @(posedge i_clock);
        tick <= 1'b0;
        apb(1'b0, ctpwm_pkg::OFS_COUNT, 32'h0000_0000);
        chk("count steps", q, 32'h0000_0005);
        tick <= 1'b1;
    endtask
    task t_compare;
        setup(ctl1(ctpwm_pkg::MODE_COMPARE, ctpwm_pkg::CM_TOGGLE, 1'b0, 1'b0, 1'b0, 1'b1),
            3'h1, 10'd200);
        run(150);
        chk("pin through p match", 32'(hi), 32'h0000_0000);
        run(60);
        chk("pin after a match", {31'h0, level}, 32'h0000_0001);
        apb(1'b0, ctpwm_pkg::OFS_STATUS, 32'h0000_0000);
        chk("flags clear on a", q, 32'h0000_0001);
        apb(1'b1, ctpwm_pkg::OFS_CTRL0, 32'h0000_0000);
        apb(1'b1, ctpwm_pkg::OFS_CTRL0, 32'h0000_0009);
        run(2);
        chk("pin initial", {31'h0, level}, 32'h0000_0000);
    endtask
    task t_timer;
        setup(ctl1(ctpwm_pkg::MODE_TIMER, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1), 3'h1, 10'd100);
        run(300);
        chk("pin released", {31'h0, oe_n}, 32'h0000_0001);
        chk("pin idle", {31'h0, pin}, 32'h0000_0000);
        apb(1'b0, ctpwm_pkg::OFS_STATUS, 32'h0000_0000);
        chk("timer flags a", q, 32'h0000_0001);
        setup(ctl1(ctpwm_pkg::MODE_TIMER, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0), 3'h1, 10'd100);
        run(300);
        apb(1'b1, ctpwm_pkg::OFS_CTRL0, 32'h0000_0000);
        apb(1'b0, ctpwm_pkg::OFS_STATUS, 32'h0000_0000);
        chk("timer flags ap", q, 32'h0000_0003);
        apb(1'b0, ctpwm_pkg::OFS_COUNT, 32'h0000_0000);
        chk("cleared by p", {31'h0, q < 128}, 32'h0000_0001);
        setup(ctl1(ctpwm_pkg::MODE_UNDEF, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0), 3'h1, 10'd100);
        run(2);
        chk("undefined mode released", {31'h0, oe_n}, 32'h0000_0001);
    endtask
    task t_pwm;
        logic sw[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
        logic [2:0] pp[4] = '{3'h1, 3'h1, 3'h1, 3'h2};
        logic [9:0] ca[4] = '{10'd32, 10'd200, 10'd300, 10'd100};
        int win[4] = '{128, 128, 300, 256};
        int exp[4] = '{32, 128, 128, 100};
        logic [31:0] st[4] = '{32'h3, 32'h2, 32'h3, 32'h3};
        for (int i = 0; i < 4; i++) begin
            setup(ctl1(ctpwm_pkg::MODE_PWM, ctpwm_pkg::PF_WAVE, 1'b1, 1'b0, sw[i], 1'b1),
                pp[i], ca[i]);
            run(20);
            run(win[i]);
            chk("pwm high", 32'(hi), 32'(exp[i]));
            apb(1'b0, ctpwm_pkg::OFS_STATUS, 32'h0000_0000);
            chk("pwm flags", q, st[i]);
        end
    endtask
    task t_irq;
        apb(1'b1, ctpwm_pkg::OFS_CTRL0, 32'h0000_0000);
        apb(1'b1, ctpwm_pkg::OFS_ENABLE, 32'h0000_0001);
        apb(1'b0, ctpwm_pkg::OFS_ENABLE, 32'h0000_0000);
        chk("enable", q, 32'h0000_0001);
        chk("irq raised", {31'h0, irq}, 32'h0000_0001);
        apb(1'b1, ctpwm_pkg::OFS_ENABLE, 32'h0000_0000);
        apb(1'b0, ctpwm_pkg::OFS_STATUS, 32'h0000_0000);
        chk("irq masked", {31'h0, irq}, 32'h0000_0000);
        apb(1'b1, ctpwm_pkg::OFS_ENABLE, 32'h0000_0003);
        apb(1'b1, ctpwm_pkg::OFS_CLEAR, 32'h0000_0003);
        apb(1'b0, ctpwm_pkg::OFS_STATUS, 32'h0000_0000);
        chk("status cleared", q, 32'h0000_0000);
        chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
    endtask
    task t_force;
        for (int f = 0; f < 2; f++) begin
            for (int p = 0; p < 2; p++) begin
                setup(ctl1(ctpwm_pkg::MODE_PWM, 2'(f), 1'b1, 1'(p), 1'b0, 1'b0), 3'h1, 10'd32);
                // Skip the restart cycle, it shows the initial level
                run(1);
                run(128);
                chk("forced pin", 32'(hi), (f != p) ? 32'd128 : 32'd0);
                apb(1'b0, ctpwm_pkg::OFS_STATUS, 32'h0000_0000);
                chk("forced counting", {31'h0, q[1]}, 32'h0000_0001);
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge i_clock);
        i_reset <= 1'b0;
        t_reset;
        t_count;
        t_compare;
        t_timer;
        t_pwm;
        t_irq;
        t_force;
        test_done;
    end
    // Watchdog, well beyond the few thousand cycles the scenarios need
    initial begin
        #2_000_000;
        n_mismatch++;
        test_done;
    end
endmodule
